/* File: verilog/pmic_seq_params.svh */
// Purpose: named constants of the rail sequencing and control block
// Assumes: included by bare name from the package and the design files
// Notes:   offsets are byte addresses of the plain 8-bit register port
`ifndef PMIC_SEQ_PARAMS_SVH
`define PMIC_SEQ_PARAMS_SVH

// register offsets
`define REG_BUCK_CTRL_BASE 8'h00
`define REG_LINEAR_CTRL 8'h06
`define REG_SHARED_LIN_SW 8'h07
`define REG_SHARED_SW_LIN 8'h08
`define REG_RAIL_STATUS 8'h09
`define REG_PGOOD_STATUS 8'h0A
`define REG_RANGE_STATUS 8'h0B

// field positions
`define BUCK_MODE_BIT 7
`define BUCK_CODE_MSB 6
`define LIN_TWO_BIT 0
`define LIN_THREE_BIT 1
`define GPO_THREE_BIT 2
`define GPO_FOUR_BIT 3
`define SHARED_EN_BIT 0

// widths and counts
`define CODE_WIDTH 7
`define BUCK_COUNT 6
`define DATA_WIDTH 8
`define ADDR_WIDTH 8

// reset values
`define RESET_BUCK_CODE 7'h3C
`define RESET_STEP_RANGE 6'h3E
`define RESET_REG_BYTE 8'h00

// timing
`define STEP_DELAY_MS 4
`define MCLK_KHZ 100_000

`endif

/* File: verilog/pmic_seq_pkg.sv */
// Purpose: shared types of the rail sequencing and control block
// Assumes: constants come from pmic_seq_params.svh
// Notes:   holds types only
`include "pmic_seq_params.svh"

package pmic_seq_pkg;
    typedef logic [`CODE_WIDTH-1:0] vcode_t;
    typedef logic [`DATA_WIDTH-1:0] reg_byte_t;
    typedef logic [`ADDR_WIDTH-1:0] reg_addr_t;
    typedef enum logic [1:0] {
        STEP_OFF = 2'b00,
        STEP_WAIT_ON = 2'b01,
        STEP_ON = 2'b10,
        STEP_WAIT_OFF = 2'b11
    } step_state_t;
endpackage : pmic_seq_pkg

/* File: verilog/pin_sync.sv */
// Purpose: two-flop synchroniser bank for pin level inputs
// Assumes: inputs are slow levels from outside the mclk domain
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // two stages; clearing to zero reads every pin as low at reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else if (clk_en) begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : pin_sync

`default_nettype wire

/* File: verilog/rail_step_timer.sv */
// Purpose: one sequencing step: enable follows a term, optionally delayed
// Assumes: term is a synchronous level on mclk
// Notes:   delayed steps wait the same count on the way up and down
`timescale 1ns/1ns
`default_nettype none

module rail_step_timer
    import pmic_seq_pkg::*;
#(
    parameter int DELAY_CYCLES = 400_000,
    parameter bit DELAYED = 1'b1
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    // sequence term and resulting enable
    input wire logic term,
    output logic enable
);
    localparam int CW = $clog2(DELAY_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(DELAY_CYCLES - 1);

    step_state_t state_reg, state_next;
    logic [CW-1:0] count_reg;
    wire logic count_done = (count_reg == LAST);
    wire logic waiting = (state_reg == STEP_WAIT_ON) ||
                         (state_reg == STEP_WAIT_OFF);

    // term is looked at every cycle, never latched
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            STEP_OFF: begin
                if (term) begin
                    state_next = DELAYED ? STEP_WAIT_ON : STEP_ON;
                end
            end
            STEP_WAIT_ON: begin
                if (!term) begin
                    state_next = STEP_OFF;
                end else if (count_done) begin
                    state_next = STEP_ON;
                end
            end
            STEP_ON: begin
                if (!term) begin
                    state_next = DELAYED ? STEP_WAIT_OFF : STEP_OFF;
                end
            end
            STEP_WAIT_OFF: begin
                if (term) begin
                    state_next = STEP_ON;
                end else if (count_done) begin
                    state_next = STEP_OFF;
                end
            end
            default: state_next = STEP_OFF;
        endcase
    end

    // counter restarts on every state change
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= STEP_OFF;
            count_reg <= '0;
        end else if (clk_en) begin
            state_reg <= state_next;
            count_reg <= (waiting && state_next == state_reg) ?
                         count_reg + CW'(1) : '0;
        end
    end

    assign enable = (state_reg == STEP_ON) || (state_reg == STEP_WAIT_OFF);
endmodule : rail_step_timer

`default_nettype wire

/* File: verilog/pmic_rail_sequence_control.sv */
// Purpose: rail and output enable sequencing with a small register file
// Assumes: one mclk domain at 100 MHz; pins arrive asynchronously
// Notes:   regulator analog behaviour and voltage tables live elsewhere
//
// How it works
// [RQ1] rails and outputs enable from control levels and other rails' good
// [RQ2] both control inputs low together run both shutdowns at once
// [RQ3] input one falling first drops outputs one, two, then chained bucks
// [RQ4] a chained buck's delay starts only once the earlier buck is off
// [RQ5] host should not drop input one before input two
// [RQ6] input four enables switches a1 and b1, input five switch b2
// [RQ7] linear rails two and three follow register writes only
// [RQ8] the two shared register sets drive linear rail one and switch b2
// [RQ9] each buck has a force-pwm bit, clear means automatic mode
// [RQ10] every buck starts at its factory default voltage code
// [RQ11] voltage codes accept writes any time, rail on or off
// [RQ12] step range per rail is fixed at build time, not writable
// [RQ13] codes are seven bits, zero means zero volts
// [RQ14] a buck enable follows its term continuously, never latched
`timescale 1ns/1ns
`default_nettype none

`include "pmic_seq_params.svh"

module pmic_rail_sequence_control #(
    parameter int STEP_DELAY_CYCLES = `STEP_DELAY_MS * `MCLK_KHZ,
    parameter logic [`BUCK_COUNT*`CODE_WIDTH-1:0] DEFAULT_CODES =
        {`BUCK_COUNT{`RESET_BUCK_CODE}},
    parameter logic [`BUCK_COUNT-1:0] STEP_RANGE_25MV = `RESET_STEP_RANGE
) (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    // control pins
    input wire logic control_input_one,
    input wire logic control_input_two,
    input wire logic control_input_four,
    input wire logic control_input_five,
    // power-good levels of the six bucks
    input wire logic [`BUCK_COUNT-1:0] buck_pgood,
    // register port
    input wire pmic_seq_pkg::reg_addr_t reg_addr,
    input wire pmic_seq_pkg::reg_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output pmic_seq_pkg::reg_byte_t reg_rdata,
    // buck controls
    output logic [`BUCK_COUNT-1:0] buck_enable,
    output logic [`BUCK_COUNT-1:0] buck_pwm_force_bit,
    output logic [`BUCK_COUNT*`CODE_WIDTH-1:0] buck_vcode,
    output logic [`BUCK_COUNT-1:0] buck_step_25mv,
    // linear rails and load switches
    output logic linear_rail_one_en,
    output logic linear_rail_two_en,
    output logic linear_rail_three_en,
    output logic load_switch_a_one_en,
    output logic load_switch_b_one_en,
    output logic load_switch_b_two_en,
    // open-drain general outputs, index 0 is general_output_one
    output logic [3:0] general_output_o,
    output logic [3:0] general_output_oe
);
    import pmic_seq_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // a zero code means zero volts, so the rail is held off
    function automatic logic code_live(input vcode_t code);
        code_live = (code != '0); // [RQ13]
    endfunction : code_live

    // write strobe decode shared by every writable register
    function automatic logic wr_hit(input logic wr, input reg_addr_t a,
                                    input reg_addr_t off);
        wr_hit = wr && (a == off);
    endfunction : wr_hit

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    localparam int PIN_W = 4 + `BUCK_COUNT;

    logic [PIN_W-1:0] pins_sync;

    pin_sync #(
        .WIDTH(PIN_W)
    ) u_pin_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .async_in({buck_pgood, control_input_five, control_input_four,
                   control_input_two, control_input_one}),
        .sync_out(pins_sync)
    );

    wire logic ctl_one_s = pins_sync[0];
    wire logic ctl_two_s = pins_sync[1];
    wire logic ctl_four_s = pins_sync[2];
    wire logic ctl_five_s = pins_sync[3];
    wire logic [`BUCK_COUNT-1:0] pg_s = pins_sync[PIN_W-1:4];

    ////////////////////////////////////////////////////////////////////////
    // registers

    vcode_t code_reg [`BUCK_COUNT];
    logic [`BUCK_COUNT-1:0] mode_reg;
    reg_byte_t linear_ctrl_reg;
    logic shared_lin_sw_reg;
    logic shared_sw_lin_reg;

    // writes land whenever addressed; rail state does not gate them
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `BUCK_COUNT; i++) begin // [RQ10]
                code_reg[i] <= DEFAULT_CODES[i*`CODE_WIDTH +: `CODE_WIDTH];
            end
            mode_reg <= '0; // [RQ9]
        end else if (clk_en) begin
            for (int i = 0; i < `BUCK_COUNT; i++) begin
                if (wr_hit(reg_wr, reg_addr,
                           `REG_BUCK_CTRL_BASE + `ADDR_WIDTH'(i))) begin
                    code_reg[i] <= reg_wdata[`BUCK_CODE_MSB:0]; // [RQ11]
                    mode_reg[i] <= reg_wdata[`BUCK_MODE_BIT]; // [RQ9]
                end
            end
        end
    end

    // linear rail and open-drain bits; no pin reaches these
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            linear_ctrl_reg <= `RESET_REG_BYTE;
            shared_lin_sw_reg <= 1'b0;
            shared_sw_lin_reg <= 1'b0;
        end else if (clk_en) begin
            if (wr_hit(reg_wr, reg_addr, `REG_LINEAR_CTRL)) begin
                linear_ctrl_reg <= reg_wdata; // [RQ7]
            end
            if (wr_hit(reg_wr, reg_addr, `REG_SHARED_LIN_SW)) begin
                shared_lin_sw_reg <= reg_wdata[`SHARED_EN_BIT]; // [RQ8]
            end
            if (wr_hit(reg_wr, reg_addr, `REG_SHARED_SW_LIN)) begin
                shared_sw_lin_reg <= reg_wdata[`SHARED_EN_BIT]; // [RQ8]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequence terms

    logic [`BUCK_COUNT-1:0] step_en;
    logic [`BUCK_COUNT-1:0] step_term;

    // chain one: input one, then each buck on the previous buck's good.
    // using the previous step's enable as well as its good means a
    // chained buck only starts its off delay once its parent is off.
    assign step_term[0] = ctl_one_s; // [RQ1]
    assign step_term[1] = step_en[0] && pg_s[0]; // [RQ1] [RQ4]
    assign step_term[2] = step_en[1] && pg_s[1]; // [RQ1] [RQ4]
    // chain two: input two gates every step, so dropping it stops them
    // all directly, in parallel with whatever chain one is doing
    assign step_term[3] = ctl_two_s && step_en[2] && pg_s[2]; // [RQ2]
    assign step_term[4] = ctl_two_s && step_en[3] && pg_s[3]; // [RQ2]
    assign step_term[5] = ctl_two_s && step_en[4] && pg_s[4]; // [RQ2]

    // only the first step follows a pin alone; good-triggered steps are delayed
    for (genvar g = 0; g < `BUCK_COUNT; g++) begin : g_step
        rail_step_timer #(
            .DELAY_CYCLES(STEP_DELAY_CYCLES),
            .DELAYED(g != 0)
        ) u_step (
            .mclk(mclk),
            .rst_n(rst_n),
            .clk_en(clk_en),
            .term(step_term[g]), // [RQ14]
            .enable(step_en[g])
        );
    end

    // outputs one and two need input one too, so its early fall drops
    // them at once while the bucks unwind one delay at a time
    wire logic gpo_one_up = ctl_one_s && step_en[2] && pg_s[2]; // [RQ3]
    wire logic gpo_two_up = ctl_one_s && step_en[5] && pg_s[5]; // [RQ3]

    ////////////////////////////////////////////////////////////////////////
    // output flops

    logic [`BUCK_COUNT-1:0] code_ok;
    logic [`BUCK_COUNT*`CODE_WIDTH-1:0] code_flat;

    always_comb begin
        for (int i = 0; i < `BUCK_COUNT; i++) begin
            code_ok[i] = code_live(code_reg[i]);
            code_flat[i*`CODE_WIDTH +: `CODE_WIDTH] = code_reg[i];
        end
    end

    // every output is a flop; the extra cycle is immaterial next to
    // millisecond sequencing steps
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            buck_enable <= '0;
            buck_pwm_force_bit <= '0;
            buck_vcode <= '0;
            buck_step_25mv <= '0;
        end else if (clk_en) begin
            buck_enable <= step_en & code_ok; // [RQ1] [RQ13]
            buck_pwm_force_bit <= mode_reg; // [RQ9]
            buck_vcode <= code_flat; // [RQ11]
            buck_step_25mv <= STEP_RANGE_25MV; // [RQ12]
        end
    end

    // linear rails, switches and open-drain outputs
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            linear_rail_one_en <= 1'b0;
            linear_rail_two_en <= 1'b0;
            linear_rail_three_en <= 1'b0;
            load_switch_a_one_en <= 1'b0;
            load_switch_b_one_en <= 1'b0;
            load_switch_b_two_en <= 1'b0;
            general_output_o <= '0;
            general_output_oe <= '1;
        end else if (clk_en) begin
            linear_rail_one_en <= shared_lin_sw_reg; // [RQ8]
            linear_rail_two_en <= linear_ctrl_reg[`LIN_TWO_BIT]; // [RQ7]
            linear_rail_three_en <= linear_ctrl_reg[`LIN_THREE_BIT]; // [RQ7]
            load_switch_a_one_en <= ctl_four_s; // [RQ6]
            load_switch_b_one_en <= ctl_four_s; // [RQ6]
            load_switch_b_two_en <= ctl_five_s || shared_sw_lin_reg; // [RQ6]
            general_output_o <= '0;
            // open drain: drive low unless the output is released high
            general_output_oe <= ~{linear_ctrl_reg[`GPO_FOUR_BIT],
                                   linear_ctrl_reg[`GPO_THREE_BIT],
                                   gpo_two_up, gpo_one_up}; // [RQ3]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path

    logic [`BUCK_COUNT-1:0] buck_hit;
    reg_byte_t buck_rd;

    // buck window decode, shared bus so at most one match
    always_comb begin
        buck_rd = '0;
        for (int i = 0; i < `BUCK_COUNT; i++) begin
            buck_hit[i] = (reg_addr == `REG_BUCK_CTRL_BASE + `ADDR_WIDTH'(i));
            if (buck_hit[i]) begin
                buck_rd = {mode_reg[i], code_reg[i]};
            end
        end
    end

    wire reg_byte_t rd_mux =
        (|buck_hit) ? buck_rd :
        (reg_addr == `REG_LINEAR_CTRL) ? linear_ctrl_reg :
        (reg_addr == `REG_SHARED_LIN_SW) ?
            reg_byte_t'(shared_lin_sw_reg) :
        (reg_addr == `REG_SHARED_SW_LIN) ?
            reg_byte_t'(shared_sw_lin_reg) :
        (reg_addr == `REG_RAIL_STATUS) ? reg_byte_t'(step_en) :
        (reg_addr == `REG_PGOOD_STATUS) ? reg_byte_t'(pg_s) :
        (reg_addr == `REG_RANGE_STATUS) ?
            reg_byte_t'(STEP_RANGE_25MV) : // [RQ12]
        `RESET_REG_BYTE; // unmapped reads as zero

    // read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `RESET_REG_BYTE;
        end else if (clk_en) begin
            reg_rdata <= reg_rd ? rd_mux : `RESET_REG_BYTE;
        end
    end
endmodule : pmic_rail_sequence_control

`default_nettype wire

/* File: sim/pmic_seq_checker_assertions.sv */
// Purpose: port checks of the rail sequencing block
// Assumes: one mclk domain; pins cross two sync flops
// Notes:   repeat counts leave slack for the sync and output flops
`timescale 1ns/1ns
`default_nettype none
`include "pmic_seq_params.svh"

module pmic_seq_checker #(
    parameter int STEP_DELAY_CYCLES = 400_000,
    parameter logic [5:0] STEP_RANGE_25MV = `RESET_STEP_RANGE
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    // inputs
    input wire logic control_input_one,
    input wire logic control_input_two,
    input wire logic [5:0] buck_pgood,
    input wire pmic_seq_pkg::reg_addr_t reg_addr,
    input wire logic reg_wr,
    // outputs
    input wire logic [5:0] buck_enable,
    input wire logic [41:0] buck_vcode,
    input wire logic [5:0] buck_step_25mv,
    input wire logic linear_rail_two_en,
    input wire logic [3:0] general_output_oe
);
    import pmic_seq_pkg::*;
    logic [5:0] en_d_reg;
    logic [19:0] held_reg;
    wire [5:0] rise = buck_enable & ~en_d_reg;
    wire held = buck_enable[0] && buck_pgood[0];

    // counts cycles that buck one stays up and good, saturating
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            en_d_reg <= '0;
            held_reg <= '0;
        end else begin
            en_d_reg <= buck_enable;
            if (!held)
                held_reg <= '0;
            else if (clk_en && held_reg != '1)
                held_reg <= held_reg + 1'b1;
        end
    end

    ////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_buck0_on;
        (clk_en && control_input_one && buck_vcode[6:0] != 7'h00) [*6]
            |-> buck_enable[0];
    endproperty
    a_buck0_on: assert property (p_buck0_on)
        else $error("buck one missed input one");
    property p_buck0_off;
        (clk_en && !control_input_one) [*6] |-> !buck_enable[0];
    endproperty
    a_buck0_off: assert property (p_buck0_off)
        else $error("buck one stayed on");
    property p_code_zero;
        (buck_vcode[41:35] == 7'h00) [*2] |-> !buck_enable[5];
    endproperty
    a_code_zero: assert property (p_code_zero)
        else $error("buck six on with zero code");
    property p_chain_delay;
        rise[1] |-> held_reg >= STEP_DELAY_CYCLES;
    endproperty
    a_chain_delay: assert property (p_chain_delay)
        else $error("buck two rose before its delay");
    property p_in_two;
        (|rise[5:3]) |-> $past(control_input_two, 3);
    endproperty
    a_in_two: assert property (p_in_two)
        else $error("late buck rose without input two");
    property p_out_low;
        (clk_en && !control_input_one) [*6]
            |-> general_output_oe[1:0] == 2'b11;
    endproperty
    a_out_low: assert property (p_out_low)
        else $error("outputs one and two not pulled low");
    property p_linear_wr;
        $changed(linear_rail_two_en)
            |-> $past(reg_wr && clk_en && reg_addr == 8'h06, 2);
    endproperty
    a_linear_wr: assert property (p_linear_wr)
        else $error("linear rail two moved without a write");
    property p_step_fixed;
        $past(rst_n) && $past(clk_en) |-> buck_step_25mv == STEP_RANGE_25MV;
    endproperty
    a_step_fixed: assert property (p_step_fixed)
        else $error("step range changed");
endmodule : pmic_seq_checker

bind pmic_rail_sequence_control pmic_seq_checker #(
    .STEP_DELAY_CYCLES(STEP_DELAY_CYCLES),
    .STEP_RANGE_25MV(STEP_RANGE_25MV)
) u_seq_chk (
    .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
    .control_input_one(control_input_one),
    .control_input_two(control_input_two), .buck_pgood(buck_pgood),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .buck_enable(buck_enable),
    .buck_vcode(buck_vcode), .buck_step_25mv(buck_step_25mv),
    .linear_rail_two_en(linear_rail_two_en),
    .general_output_oe(general_output_oe)
);
`default_nettype wire

/* File: sim/rail_pgood_model.sv */
// Purpose: far-side rails, power-good follows each buck enable
// Assumes: enables are levels on the bench clock
// Notes:   slow mode stretches settling to stress the chain timing
`timescale 1ns/1ns
`default_nettype none

module rail_pgood_model (
    // clock and mode
    input wire logic mclk,
    input wire logic slow,
    // rails
    input wire logic [5:0] buck_enable,
    output logic [5:0] buck_pgood
);
    int settle[6];

    initial buck_pgood = '0;

    // good drops at once when a rail goes off, so no stale level lingers
    always @(posedge mclk) begin
        for (int i = 0; i < 6; i++) begin
            if (!buck_enable[i]) begin
                settle[i] = 0;
                buck_pgood[i] <= 1'b0;
            end else if (settle[i] < (slow ? 6 : 1)) begin
                settle[i] = settle[i] + 1;
            end else begin
                buck_pgood[i] <= 1'b1;
            end
        end
    end
endmodule : rail_pgood_model
`default_nettype wire

/* File: sim/test_pmic_rail_sequence_control.sv */
// Purpose: self-checking bench of the rail sequencing block
// Assumes: step delay cut to 8 cycles; rails come from a partner model
// Notes:   an int register image predicts every read and the register-fed outputs
`timescale 1ns/1ns
`default_nettype none
`include "pmic_seq_params.svh"

module test_pmic_rail_sequence_control;
    import pmic_seq_pkg::*;
    localparam int D = 8;
    logic mclk, rst_n, clk_en, in_one, in_two, in_four, in_five;
    logic reg_wr, reg_rd, slow, lin1, lin2, lin3, sw_a1, sw_b1, sw_b2;
    reg_addr_t reg_addr;
    reg_byte_t reg_wdata, reg_rdata, v;
    logic [5:0] pgood, buck_en, pwm, step, pexp;
    logic [41:0] vcode, vexp;
    logic [3:0] gpo_o, gpo_oe;
    int errors, checks, n, step_img, pg_img, regm[9];

    pmic_rail_sequence_control #(.STEP_DELAY_CYCLES(D)) dut (
        .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
        .control_input_one(in_one), .control_input_two(in_two),
        .control_input_four(in_four), .control_input_five(in_five),
        .buck_pgood(pgood), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .buck_enable(buck_en), .buck_pwm_force_bit(pwm),
        .buck_vcode(vcode), .buck_step_25mv(step),
        .linear_rail_one_en(lin1), .linear_rail_two_en(lin2),
        .linear_rail_three_en(lin3), .load_switch_a_one_en(sw_a1),
        .load_switch_b_one_en(sw_b1), .load_switch_b_two_en(sw_b2),
        .general_output_o(gpo_o), .general_output_oe(gpo_oe));
    rail_pgood_model rails (.mclk(mclk), .slow(slow),
        .buck_enable(buck_en), .buck_pgood(pgood));

    initial mclk = 1'b0;
    always #5 mclk = ~mclk;

    ////////////////////////////////////////
    task automatic chk(input string what, input logic [41:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic tick(input int c);
        repeat (c) @(posedge mclk);
        #1;
    endtask : tick

    task automatic reset_img();
        foreach (regm[i])
            regm[i] = (i < 6) ? `RESET_BUCK_CODE : 0;
        step_img = 0;
        pg_img = 0;
    endtask : reset_img

    function automatic logic [7:0] expv(input int a);
        if (a < 9) return regm[a][7:0];
        if (a == 9) return step_img[7:0];
        if (a == 10) return pg_img[7:0];
        if (a == 11) return {2'b00, `RESET_STEP_RANGE};
        return 8'h00;
    endfunction : expv

    task automatic wr(input int a, input int d);
        @(posedge mclk);
        reg_addr <= a[7:0];
        reg_wdata <= d[7:0];
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        if (a < 9) regm[a] = d & (a > 6 ? 1 : 8'hFF);
    endtask : wr

    task automatic rd(input int a);
        @(posedge mclk);
        reg_addr <= a[7:0];
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", reg_rdata, expv(a));
    endtask : rd

    // includes one unmapped address that must read back zero
    task automatic read_all();
        for (int a = 0; a < 13; a++)
            rd(a == 12 ? 8'h40 : a);
    endtask : read_all

    // bounded wait for one enable level; n returns the cycles spent
    task automatic wait_en(input int k, input logic lvl, input int lim);
        n = 0;
        while (buck_en[k] !== lvl && n < lim) begin
            tick(1);
            n++;
        end
        chk("buck_enable", buck_en[k], lvl);
    endtask : wait_en

    task automatic finish_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    ////////////////////////////////////////
    initial begin
        #100_000;
        errors++;
        $display("[FAIL] watchdog expected finish seen hang");
        finish_test();
    end

    initial begin
        {in_one, in_two, in_four, in_five, reg_wr, reg_rd, slow} = '0;
        reg_addr = '0;
        reg_wdata = '0;
        clk_en = 1'b1;
        rst_n = 1'b0;
        errors = 0;
        checks = 0;
        reset_img();
        void'($urandom(75883));
        repeat (4) @(posedge mclk);
        chk("oe_reset", gpo_oe, 4'hF);
        rst_n <= 1'b1;
        tick(2);
        chk("vcode", vcode, {6{`RESET_BUCK_CODE}});
        chk("range", step, `RESET_STEP_RANGE);
        read_all();
        $display("reset test done");
        // random writes, read-only and unmapped places among them
        for (int a = 0; a < 13; a++) begin
            v = $urandom;
            if (a < 6 && v[6:0] == 7'h00) v[0] = 1'b1;
            wr(a == 12 ? 8'h40 : a, v);
        end
        read_all();
        tick(2);
        for (int i = 0; i < 6; i++) begin
            vexp[7*i +: 7] = regm[i][6:0];
            pexp[i] = regm[i][7];
        end
        chk("vcode", vcode, vexp);
        chk("pwm", pwm, pexp);
        chk("linear", {lin1, lin3, lin2},
            {regm[7][0], regm[6][1], regm[6][0]});
        chk("sw_b2", sw_b2, regm[8][0]);
        chk("idle", buck_en, 6'h00);
        $display("register test done");
        @(posedge mclk);
        in_two <= 1'b1;
        in_one <= 1'b1;
        wait_en(0, 1'b1, 8);
        for (int k = 1; k < 6; k++) begin
            wait_en(k, 1'b1, D + 12);
            chk("up_gap", n >= D, 1'b1);
        end
        tick(4);
        step_img = 8'h3F;
        pg_img = 8'h3F;
        read_all();
        chk("gpo_oe", gpo_oe, {~regm[6][3], ~regm[6][2], 2'b00});
        chk("gpo_o", gpo_o, 4'h0);
        $display("power-up test done");
        wr(5, 8'h80);
        wait_en(5, 1'b0, 6);
        wr(5, 8'h81);
        wait_en(5, 1'b1, 6);
        chk("pwm5", pwm[5], 1'b1);
        wr(5, 8'h05);
        tick(2);
        chk("auto5", pwm[5], 1'b0);
        $display("code test done");
        // a stopped clock enable must freeze the whole sequence
        @(posedge mclk);
        clk_en <= 1'b0;
        in_one <= 1'b0;
        tick(10);
        chk("frozen", buck_en, 6'h3F);
        @(posedge mclk);
        clk_en <= 1'b1;
        wait_en(0, 1'b0, 8);
        for (int k = 1; k < 6; k++) begin
            wait_en(k, 1'b0, D + 12);
            chk("down_gap", n >= D, 1'b1);
        end
        chk("gpo_low", gpo_oe[1:0], 2'b11);
        $display("early drop test done");
        @(posedge mclk);
        slow <= 1'b1;
        in_one <= 1'b1;
        for (int k = 0; k < 6; k++)
            wait_en(k, 1'b1, D + 16);
        @(posedge mclk);
        in_one <= 1'b0;
        in_two <= 1'b0;
        wait_en(5, 1'b0, D + 8);
        chk("late_off", buck_en[5:3], 3'b000);
        @(posedge mclk);
        rst_n <= 1'b0;
        tick(2);
        chk("oe_reset", gpo_oe, 4'hF);
        @(posedge mclk);
        rst_n <= 1'b1;
        reset_img();
        tick(2);
        read_all();
        $display("joint drop test done");
        for (int i = 0; i < 8; i++) begin
            wr(8, i & 1);
            @(posedge mclk);
            in_four <= i[1];
            in_five <= i[2];
            tick(5);
            chk("sw_a1", sw_a1, i[1]);
            chk("sw_b1", sw_b1, i[1]);
            chk("sw_b2", sw_b2, i[2] | i[0]);
        end
        $display("switch test done");
        finish_test();
    end
endmodule : test_pmic_rail_sequence_control
`default_nettype wire
